// [hdl/gauge_i2c_params.svh]
`ifndef GAUGE_I2C_PARAMS_SVH
`define GAUGE_I2C_PARAMS_SVH

// ****************************************************************
// Link addressing and command map
// ****************************************************************
`define TGT_ADDR          7'h55
`define CMD_LAST_READ     8'h6B
`define CMD_WR_LIMIT      8'h02
`define MEM_DEPTH         128

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ           250
`define BUS_TIMEOUT_MS    2000
`define FLASH_STRETCH_MS  80
`define DEEP_IDLE_HOLD_US 4000
`define CMD_GAP_US        66
`define CHECKSUM_WAIT_MS  100
`define OCV_WAIT_MS       1200
`define RW_STD_WAIT_MS    2000
`define SETTLE_CYC        8
`define SCL_HALF_CYC      16
`define US_TO_CYC(t)      ((t) * `CLK_MHZ)
`define MS_TO_CYC(t)      ((t) * `CLK_MHZ * 1000)

`endif

// [hdl/gauge_i2c_pkg.sv]
`include "gauge_i2c_params.svh"

package gauge_i2c_pkg;

  typedef struct packed {
    logic [2:0] stg;
    logic       lvl;
  } sync_t;

  typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK} dev_state_t;
  typedef enum logic [1:0] {R_ADDR, R_CMD, R_DATA} byte_role_t;

  typedef struct packed {
    dev_state_t                   st;
    byte_role_t                   role;
    logic                         sclP;
    logic                         sdaP;
    logic [3:0]                   cnt;
    logic [7:0]                   sh;
    logic [7:0]                   tx;
    logic [7:0]                   ptr;
    logic                         rw;
    logic                         mAck;
    logic                         sclOe;
    logic                         sdaOe;
    logic [24:0]                  hold;
    logic [28:0]                  tmo;
    logic                         sleep;
    logic                         wake;
    logic                         wrStb;
    logic [7:0]                   wrAddr;
    logic [7:0]                   wrData;
    logic [`MEM_DEPTH-1:0][7:0]   mem;
  } dev_t;

  typedef enum logic [3:0] {
    H_IDLE, H_START, H_LOW, H_HIGH, H_RST, H_RST_B, H_STOP_A, H_STOP_B, H_GAP
  } host_state_t;
  typedef enum logic [2:0] {S_ADDR1, S_CMD, S_WR, S_ADDR2, S_RD} host_stage_t;
  typedef enum logic [1:0] {WAIT_CMD_GAP, WAIT_CHECKSUM, WAIT_OCV, WAIT_RW_STD} wait_kind_t;

  typedef struct packed {
    host_state_t st;
    host_stage_t stage;
    logic [3:0]  bitN;
    logic [7:0]  sh;
    logic [5:0]  tmr;
    logic [28:0] gap;
    logic        sclOe;
    logic        sdaOe;
    logic        rd;
    logic        quick;
    logic [7:0]  cmd;
    logic [1:0]  len;
    logic [1:0]  idx;
    logic [15:0] wdat;
    logic [15:0] rdat;
    wait_kind_t  wk;
    logic        rdy;
    logic        rspV;
    logic        nack;
  } host_t;

endpackage

// [hdl/i2c_link_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface i2c_link_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSclOut;
  logic devSclOe;
  logic devSdaOut;
  logic devSdaOe;
  logic extSclLow;
  logic extSdaLow;
  logic scl;
  logic sda;

  // Open-drain wire: any enabled driver pulls the line low.
  assign scl = ~(hostSclOe | devSclOe | extSclLow);
  assign sda = ~(hostSdaOe | devSdaOe | extSdaLow);

  modport device (input scl, input sda,
                  output devSclOut, output devSclOe, output devSdaOut, output devSdaOe);
  modport host   (input scl, input sda,
                  output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe);
endinterface

`default_nettype wire

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_sync
  import gauge_i2c_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic pinIn,
  output logic      level
);
  sync_t q;
  sync_t d;

  // Resets to ones because an idle open-drain line reads high.
  always_comb begin
    d     = q;
    d.stg = {q.stg[1:0], pinIn};
    if (q.stg[1] == q.stg[2]) begin
      d.lvl = q.stg[2];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule // pin_sync

`default_nettype wire

// [hdl/gauge_i2c_target_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gauge_i2c_params.svh"

// Overview of operation
// (RL1) Accept read, quick read, write formats.
// (RL2) Answer only target address 1010101.
// (RL3) Quick read returns byte at pointer.
// (RL4) Pointer advances on every acknowledged data byte.
// (RL5) Write bytes land in consecutive locations.
// (RL6) Refuse data written to read-only location.
// (RL7) Refuse command byte above 0x6B.
// (RL8) Release both lines after 2 s low.
// (RL9) Still held low afterwards: enter sleep.
// (RL10) Host waits 66 us after subcommand.
// (RL11) Host spaces result reads 66 us apart.
// (RL12) Host waits 100 ms after checksum.
// (RL13) Host waits 1.2 s after voltage measure.
// (RL14) Host waits 2 s after read-write command.
// (RL15) Host polls full command set at most twice/s; the code enforces no such rate, only the per-transfer wait.
// (RL16) Clock stretch up to 80 ms tolerated.
// (RL17) Deep idle may hold bus 4 ms.
// (RL18) Wake only on own address.
// (RL19) First written byte loads the pointer.

module gauge_i2c_target_port
  import gauge_i2c_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `MS_TO_CYC(`BUS_TIMEOUT_MS),
  parameter int unsigned STRETCH_CYC = `MS_TO_CYC(`FLASH_STRETCH_MS),
  parameter int unsigned WAKE_CYC    = `US_TO_CYC(`DEEP_IDLE_HOLD_US)
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       flashBusy,
  input  wire logic       deepIdle,
  input  wire logic       lowPower,
  input  wire logic       gaugeWrEn,
  input  wire logic [6:0] gaugeWrAddr,
  input  wire logic [7:0] gaugeWrData,
  output logic            hostWrStb,
  output logic [7:0]      hostWrAddr,
  output logic [7:0]      hostWrData,
  output logic            wakeReq,
  output logic            sleepState,
  i2c_link_if.device      link
);

  // ****************************************************************
  // Constants and helpers
  // ****************************************************************
  localparam logic [28:0] TMO_REL     = 29'(TIMEOUT_CYC);
  localparam logic [28:0] TMO_END     = 29'(TIMEOUT_CYC + `SETTLE_CYC);
  localparam logic [24:0] STRETCH_END = 25'(STRETCH_CYC - 1);
  localparam logic [24:0] WAKE_END    = 25'(WAKE_CYC - 1);

  // Locations past the last readable one read as zero.
  function automatic logic [7:0] readByte(input logic [7:0]                 p,
                                          input logic [`MEM_DEPTH-1:0][7:0] m);
    readByte = (p <= `CMD_LAST_READ) ? m[p[6:0]] : 8'h00;
  endfunction

  dev_t q;
  dev_t d;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [7:0] nextTx;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pin_sync u_sclSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pinIn   (link.scl),
    .level   (scl)
  );
  pin_sync u_sdaSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pinIn   (link.sda),
    .level   (sda)
  );

  assign rise   = scl & ~q.sclP;
  assign fall   = ~scl & q.sclP;
  assign start  = q.sclP & scl & q.sdaP & ~sda;
  assign stop   = q.sclP & scl & ~q.sdaP & sda;
  assign nextTx = readByte(q.ptr, q.mem);

  // ****************************************************************
  // Serial engine
  // ****************************************************************
  always_comb begin
    d       = q;
    d.wrStb = 1'b0;
    d.wake  = 1'b0;
    d.sclP  = scl;
    d.sdaP  = sda;
    if (gaugeWrEn) begin
      d.mem[gaugeWrAddr] = gaugeWrData;
    end
    if (scl && sda) begin
      d.tmo = '0;
    end else if (q.tmo != TMO_END) begin
      d.tmo = q.tmo + 29'h1;
    end
    // The settle margin lets our own release reach the synchronisers first.
    d.sleep = (q.tmo == TMO_END); // RL9
    if (q.tmo >= TMO_REL) begin // RL8
      d.st    = D_IDLE;
      d.sclOe = 1'b0;
      d.sdaOe = 1'b0;
    end else if (start) begin // RL1
      d.st    = D_RECV;
      d.role  = R_ADDR;
      d.cnt   = '0;
      d.sclOe = 1'b0;
      d.sdaOe = 1'b0;
    end else if (stop) begin
      d.st    = D_IDLE;
      d.sdaOe = 1'b0;
    end else begin
      case (q.st)
        D_RECV: begin
          if (rise) begin
            d.sh  = {q.sh[6:0], sda};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == 4'h8) begin
            d.cnt   = '0;
            d.hold  = '0;
            d.st    = D_ACK;
            d.sdaOe = 1'b1;
            case (q.role)
              R_ADDR: begin
                if (q.sh[7:1] == `TGT_ADDR) begin // RL2
                  d.rw    = q.sh[0];
                  d.wake  = lowPower | deepIdle; // RL18
                  d.sclOe = deepIdle; // RL17
                end else begin
                  d.st    = D_IDLE; // RL18
                  d.sdaOe = 1'b0;
                end
              end
              R_CMD: begin
                if (q.sh > `CMD_LAST_READ) begin
                  d.st    = D_IDLE; // RL7
                  d.sdaOe = 1'b0;
                end else begin
                  d.ptr = q.sh; // RL19
                end
              end
              default: begin
                if (q.ptr < `CMD_WR_LIMIT) begin
                  d.mem[q.ptr[6:0]] = q.sh; // RL5
                  d.wrStb  = 1'b1;
                  d.wrAddr = q.ptr;
                  d.wrData = q.sh;
                  d.ptr    = q.ptr + 8'h01; // RL4
                  d.sclOe  = flashBusy; // RL16
                end else begin
                  d.st    = D_IDLE; // RL6
                  d.sdaOe = 1'b0;
                end
              end
            endcase
          end
        end
        D_ACK: begin
          if (q.sclOe) begin
            // Stretching ends when the cause clears or its cap is hit.
            d.hold = q.hold + 25'h1;
            if (q.role == R_ADDR) begin
              if (!deepIdle || q.hold == WAKE_END) begin
                d.sclOe = 1'b0; // RL17
              end
            end else if (!flashBusy || q.hold == STRETCH_END) begin
              d.sclOe = 1'b0; // RL16
            end
          end else if (fall) begin
            if (q.role == R_ADDR && q.rw) begin
              d.sdaOe = ~nextTx[7]; // RL3
              d.tx    = {nextTx[6:0], 1'b0};
              d.cnt   = 4'h1;
              d.st    = D_SEND;
            end else begin
              d.sdaOe = 1'b0;
              d.st    = D_RECV;
              d.role  = (q.role == R_ADDR) ? R_CMD : R_DATA;
            end
          end
        end
        D_SEND: begin
          if (fall) begin
            if (q.cnt == 4'h8) begin
              d.sdaOe = 1'b0;
              d.st    = D_MACK;
            end else begin
              d.sdaOe = ~q.tx[7];
              d.tx    = {q.tx[6:0], 1'b0};
              d.cnt   = q.cnt + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            d.mAck = ~sda;
            if (!sda) begin
              d.ptr = q.ptr + 8'h01; // RL4
            end
          end else if (fall) begin
            if (q.mAck) begin
              d.sdaOe = ~nextTx[7];
              d.tx    = {nextTx[6:0], 1'b0};
              d.cnt   = 4'h1;
              d.st    = D_SEND;
            end else begin
              d.st = D_IDLE;
            end
          end
        end
        default: begin
          d.st = D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q      <= '0;
      // Idle lines read high, so the edge history starts high to avoid a false rise.
      q.sclP <= 1'b1;
      q.sdaP <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign hostWrStb      = q.wrStb;
  assign hostWrAddr     = q.wrAddr;
  assign hostWrData     = q.wrData;
  assign wakeReq        = q.wake;
  assign sleepState     = q.sleep;
  assign link.devSclOe  = q.sclOe;
  assign link.devSdaOe  = q.sdaOe;
  assign link.devSclOut = 1'b0;
  assign link.devSdaOut = 1'b0;

endmodule // gauge_i2c_target_port

`default_nettype wire

// [hdl/gauge_i2c_host_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gauge_i2c_params.svh"

module gauge_i2c_host_port
  import gauge_i2c_pkg::*;
#(
  parameter int unsigned GAP_CYC      = `US_TO_CYC(`CMD_GAP_US),
  parameter int unsigned CHECKSUM_CYC = `MS_TO_CYC(`CHECKSUM_WAIT_MS),
  parameter int unsigned OCV_CYC      = `MS_TO_CYC(`OCV_WAIT_MS),
  parameter int unsigned RW_STD_CYC   = `MS_TO_CYC(`RW_STD_WAIT_MS)
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        reqValid,
  input  wire logic        reqRead,
  input  wire logic        reqQuick,
  input  wire logic [7:0]  reqCmd,
  input  wire logic [1:0]  reqLen,
  input  wire logic [15:0] reqWrData,
  input  wire wait_kind_t  reqWait,
  output logic             reqReady,
  output logic             rspValid,
  output logic [15:0]      rspData,
  output logic             rspNack,
  i2c_link_if.host         link
);

  localparam logic [5:0] HALF_END = 6'(`SCL_HALF_CYC - 1);
  localparam logic [5:0] HALF_MID = 6'(`SCL_HALF_CYC / 2);

  function automatic logic lastByte(input logic [1:0] idx, input logic [1:0] len);
    lastByte = ((idx + 2'h1) == len);
  endfunction

  function automatic logic [28:0] gapCycles(input wait_kind_t k);
    case (k)
      WAIT_CHECKSUM: gapCycles = 29'(CHECKSUM_CYC); // RL12
      WAIT_OCV:      gapCycles = 29'(OCV_CYC); // RL13
      WAIT_RW_STD:   gapCycles = 29'(RW_STD_CYC); // RL14
      default:       gapCycles = 29'(GAP_CYC); // RL10 RL11 RL15
    endcase
  endfunction

  host_t q;
  host_t d;
  logic  scl;
  logic  sda;
  logic  tx;

  pin_sync u_sclSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pinIn   (link.scl),
    .level   (scl)
  );
  pin_sync u_sdaSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pinIn   (link.sda),
    .level   (sda)
  );

  assign tx = (q.stage != S_RD);

  // ****************************************************************
  // Bit engine
  // ****************************************************************
  // Data changes mid low phase so the target never sees a false start.
  always_comb begin
    d      = q;
    d.rspV = 1'b0;
    case (q.st)
      H_IDLE: begin
        d.rdy = 1'b1;
        if (reqValid && q.rdy && scl && sda) begin
          d.rdy   = 1'b0;
          d.nack  = 1'b0;
          d.rd    = reqRead;
          d.quick = reqRead & reqQuick;
          d.cmd   = reqCmd;
          d.len   = reqLen;
          d.wdat  = reqWrData;
          d.wk    = reqWait;
          d.idx   = '0;
          d.stage = S_ADDR1;
          d.sh    = {`TGT_ADDR, reqRead & reqQuick}; // RL2
          d.sdaOe = 1'b1;
          d.tmr   = '0;
          d.st    = H_START;
        end
      end
      H_START: begin
        d.tmr = q.tmr + 6'h1;
        if (q.tmr == HALF_END) begin
          d.sclOe = 1'b1;
          d.tmr   = '0;
          d.bitN  = '0;
          d.st    = H_LOW;
        end
      end
      H_LOW, H_RST, H_STOP_A: begin
        d.tmr = q.tmr + 6'h1;
        if (q.tmr == HALF_MID) begin
          if (q.st == H_RST) begin
            d.sdaOe = 1'b0;
          end else if (q.st == H_STOP_A) begin
            d.sdaOe = 1'b1;
          end else if (q.bitN != 4'h8) begin
            d.sdaOe = tx & ~q.sh[7];
          end else begin
            d.sdaOe = ~tx & ~lastByte(q.idx, q.len);
          end
        end
        if (q.tmr == HALF_END) begin
          d.sclOe = 1'b0;
          d.tmr   = '0;
          d.st    = (q.st == H_RST) ? H_RST_B : (q.st == H_STOP_A) ? H_STOP_B : H_HIGH;
        end
      end
      H_HIGH, H_RST_B, H_STOP_B: begin
        if (!scl) begin
          d.tmr = '0; // RL16 RL17
        end else if (q.tmr != HALF_END) begin
          d.tmr = q.tmr + 6'h1;
        end else begin
          d.tmr = '0;
          if (q.st == H_RST_B) begin
            d.sdaOe = 1'b1;
            d.st    = H_START;
          end else if (q.st == H_STOP_B) begin
            d.sdaOe = 1'b0;
            d.rspV  = 1'b1;
            d.gap   = gapCycles(q.wk);
            d.st    = H_GAP;
          end else begin
            d.sclOe = 1'b1;
            d.st    = H_LOW;
            if (q.bitN != 4'h8) begin
              d.bitN = q.bitN + 4'h1;
              d.sh   = {q.sh[6:0], tx ? 1'b0 : sda};
            end else begin
              d.bitN = '0;
              if (tx && sda) begin
                d.nack = 1'b1;
                d.st   = H_STOP_A;
              end else begin
                case (q.stage)
                  S_ADDR1: begin
                    d.stage = q.quick ? S_RD : S_CMD; // RL1
                    d.sh    = q.cmd;
                  end
                  S_CMD: begin
                    if (q.rd) begin
                      d.stage = S_ADDR2;
                      d.sh    = {`TGT_ADDR, 1'b1};
                      d.st    = H_RST;
                    end else begin
                      d.stage = S_WR;
                      d.sh    = q.wdat[7:0];
                    end
                  end
                  S_WR: begin
                    if (lastByte(q.idx, q.len)) begin
                      d.st = H_STOP_A;
                    end else begin
                      d.idx = q.idx + 2'h1;
                      d.sh  = q.wdat[15:8];
                    end
                  end
                  S_ADDR2: begin
                    d.stage = S_RD;
                  end
                  default: begin
                    d.rdat = q.idx[0] ? {q.sh, q.rdat[7:0]} : {q.rdat[15:8], q.sh};
                    if (lastByte(q.idx, q.len)) begin
                      d.st = H_STOP_A;
                    end else begin
                      d.idx = q.idx + 2'h1;
                    end
                  end
                endcase
              end
            end
          end
        end
      end
      H_GAP: begin
        if (q.gap == '0) begin
          d.st = H_IDLE;
        end else begin
          d.gap = q.gap - 29'h1;
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reqReady        = q.rdy;
  assign rspValid        = q.rspV;
  assign rspData         = q.rdat;
  assign rspNack         = q.nack;
  assign link.hostSclOe  = q.sclOe;
  assign link.hostSdaOe  = q.sdaOe;
  assign link.hostSclOut = 1'b0;
  assign link.hostSdaOut = 1'b0;

endmodule // gauge_i2c_host_port

`default_nettype wire

// [tb/gauge_i2c_link_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gauge_i2c_params.svh"

module gauge_i2c_link_props #(
  parameter int TIMEOUT_CYC = 2000,
  parameter int STRETCH_CYC = 400
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hostSclOe,
  input wire logic hostSdaOe,
  input wire logic devSclOe,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  // ********
  // Wire monitor
  // ********
  typedef struct packed {
    logic        sclP;
    logic        sdaP;
    logic        inAddr;
    logic [3:0]  bitN;
    logic [7:0]  sh;
    logic [31:0] lowN;
    logic [31:0] strN;
  } mon_t;
  mon_t s_q;
  mon_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sclP = scl;
    s_d.sdaP = sda;
    s_d.lowN = (scl && sda) ? 32'h0 : s_q.lowN + 32'h1;
    s_d.strN = devSclOe ? s_q.strN + 32'h1 : 32'h0;
    if (s_q.sclP && scl && s_q.sdaP && !sda) begin
      s_d.inAddr = 1'b1;
      s_d.bitN = 4'h0;
    end else if (s_q.inAddr && !s_q.sclP && scl) begin
      s_d.sh = {s_q.sh[6:0], sda};
      s_d.bitN = s_q.bitN + 4'h1;
      s_d.inAddr = (s_q.bitN != 4'h7);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ********
  // Properties
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  dev_sda_edge_a: assert property ($rose(devSdaOe) |-> !scl)
    else $error("device took SDA while SCL high");
  host_start_a: assert property ($rose(hostSdaOe) && scl && !hostSclOe |-> ##[1:40] hostSclOe)
    else $error("no clock after start");
  low_phase_a: assert property ($rose(hostSclOe) |-> hostSclOe [*8])
    else $error("SCL low phase too short");
  addr_match_a: assert property ($fell(s_q.inAddr) |-> s_q.sh[7:1] == `TGT_ADDR)
    else $error("wrong target address on wire");
  addr_ack_a: assert property ($fell(s_q.inAddr) |-> ##[1:40] devSdaOe)
    else $error("own address not acknowledged");
  stretch_hold_a: assert property (devSclOe && !hostSclOe && $past(devSclOe) && !$past(hostSclOe)
    |-> $stable(hostSdaOe))
    else $error("host moved SDA during stretch");
  stretch_cap_a: assert property (s_q.strN <= STRETCH_CYC + 8)
    else $error("stretch too long");
  timeout_rel_a: assert property (s_q.lowN > TIMEOUT_CYC + 16 |-> !devSclOe && !devSdaOe)
    else $error("lines not released after timeout");

  cover property (devSclOe && !hostSclOe);
  cover property (s_q.lowN == TIMEOUT_CYC);
  cover property ($fell(s_q.inAddr) && s_q.sh[0]);
endmodule // gauge_i2c_link_props

`default_nettype wire

// [tb/test_gauge_i2c_target_port.sv]
`timescale 1ns/1ps
`default_nettype none

module test_gauge_i2c_target_port;
  import gauge_i2c_pkg::*;
  localparam int TO = 2000;
  localparam int ST = 400;
  logic        clk, sys_rst, ce, reqValid, reqRead, reqQuick, flashBusy, deepIdle;
  logic        lowPower, gaugeWrEn, reqReady, rspValid, rspNack;
  logic        hostWrStb, wakeReq, sleepState;
  logic [6:0]  gaugeWrAddr;
  logic [7:0]  gaugeWrData, reqCmd, hostWrAddr, hostWrData;
  logic [1:0]  reqLen;
  logic [15:0] reqWrData, rspData;
  wait_kind_t  reqWait;
  int          bad_count, compares, woke, gapN;
  logic [15:0] wrLog[$];

  i2c_link_if link();
  gauge_i2c_target_port #(.TIMEOUT_CYC(TO), .STRETCH_CYC(ST), .WAKE_CYC(200))
    gauge_i2c_target_port_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .flashBusy(flashBusy), .deepIdle(deepIdle), .lowPower(lowPower), .gaugeWrEn(gaugeWrEn),
    .gaugeWrAddr(gaugeWrAddr), .gaugeWrData(gaugeWrData), .hostWrStb(hostWrStb),
    .hostWrAddr(hostWrAddr), .hostWrData(hostWrData), .wakeReq(wakeReq),
    .sleepState(sleepState), .link(link));
  gauge_i2c_host_port #(.GAP_CYC(50), .CHECKSUM_CYC(100), .OCV_CYC(100), .RW_STD_CYC(100))
    gauge_i2c_host_port_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reqValid(reqValid),
    .reqRead(reqRead), .reqQuick(reqQuick), .reqCmd(reqCmd), .reqLen(reqLen),
    .reqWrData(reqWrData), .reqWait(reqWait), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .rspNack(rspNack), .link(link));
  gauge_i2c_link_props #(.TIMEOUT_CYC(TO), .STRETCH_CYC(ST))
    gauge_i2c_link_props_inst (.clk(clk), .sys_rst(sys_rst), .hostSclOe(link.hostSclOe),
    .hostSdaOe(link.hostSdaOe), .devSclOe(link.devSclOe), .devSdaOe(link.devSdaOe),
    .scl(link.scl), .sda(link.sda));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (hostWrStb === 1'b1) wrLog.push_back({hostWrAddr, hostWrData});
    if (wakeReq === 1'b1) woke++;
  end

  // ********
  // Helpers
  // ********
  task test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task tmo(input logic ok, input string what);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t timeout %s", $time, what);
      test_done;
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task xfer(input logic rd, input logic qk, input logic [7:0] cmd, input logic [1:0] len,
            input logic [15:0] wd, input wait_kind_t wk);
    int i;
    for (i = 0; i < 20000 && reqReady !== 1'b1; i++) step(1);
    tmo(reqReady, "ready");
    reqRead = rd;
    reqQuick = qk;
    reqCmd = cmd;
    reqLen = len;
    reqWrData = wd;
    reqWait = wk;
    reqValid = 1'b1;
    for (i = 0; i < 200 && reqReady !== 1'b0; i++) step(1);
    tmo(~reqReady, "accept");
    reqValid = 1'b0;
    for (i = 0; i < 20000 && rspValid !== 1'b1; i++) step(1);
    tmo(rspValid, "response");
    for (gapN = 0; gapN < 20000 && reqReady !== 1'b1; gapN++) step(1);
    tmo(reqReady, "gap");
  endtask

  // ********
  // Scenarios
  // ********
  task test_write;
    for (int k = 0; k < 4; k++) begin
      wrLog.delete();
      flashBusy = (k == 3);
      xfer(1'b0, 1'b0, 8'h00, 2'h2, {8'h30 + 8'(k), 8'h10 + 8'(k)}, wait_kind_t'(k));
      chk(16'(rspNack), 16'h0, "write nack");
      chk(16'(wrLog.size()), 16'h2, "write count");
      chk(wrLog[0], {8'h00, 8'h10 + 8'(k)}, "first byte");
      chk(wrLog[1], {8'h01, 8'h30 + 8'(k)}, "second byte");
      chk(16'(gapN >= (k == 0 ? 48 : 98)), 16'h1, "wait gap");
    end
    flashBusy = 1'b0;
    $display("write test done");
  endtask

  task test_read;
    lowPower = 1'b1;
    woke = 0;
    xfer(1'b1, 1'b0, 8'h00, 2'h2, 16'h0, WAIT_CMD_GAP);
    chk(rspData, 16'h3313, "two byte read");
    // A combined read addresses the target twice, once before and once after the repeated start.
    chk(16'(woke), 16'h2, "wake pulse per address");
    lowPower = 1'b0;
    xfer(1'b1, 1'b1, 8'h00, 2'h1, 16'h0, WAIT_CMD_GAP);
    chk(rspData[7:0], 16'h33, "quick read");
    deepIdle = 1'b1;
    xfer(1'b1, 1'b1, 8'h00, 2'h1, 16'h0, WAIT_CMD_GAP);
    chk(rspData[7:0], 16'h33, "nacked byte keeps pointer");
    deepIdle = 1'b0;
    $display("read test done");
  endtask

  task test_refuse;
    wrLog.delete();
    xfer(1'b0, 1'b0, 8'h10, 2'h1, 16'h0077, WAIT_CMD_GAP);
    chk(16'(rspNack), 16'h1, "read-only nack");
    chk(16'(wrLog.size()), 16'h0, "read-only stored");
    xfer(1'b1, 1'b0, 8'h6C, 2'h1, 16'h0, WAIT_CMD_GAP);
    chk(16'(rspNack), 16'h1, "range nack");
    gaugeWrAddr = 7'h6B;
    gaugeWrData = 8'h5A;
    gaugeWrEn = 1'b1;
    step(1);
    gaugeWrEn = 1'b0;
    xfer(1'b1, 1'b0, 8'h6B, 2'h1, 16'h0, WAIT_CMD_GAP);
    chk({7'h0, rspNack, rspData[7:0]}, 16'h005A, "last location");
    $display("refuse test done");
  endtask

  task test_hold;
    fork
      xfer(1'b0, 1'b0, 8'h00, 2'h1, 16'h0044, WAIT_CMD_GAP);
      begin
        for (int i = 0; i < 2000 && link.devSdaOe !== 1'b1; i++) step(1);
        link.extSclLow = 1'b1;
        step(TO + 40);
        chk(16'({link.devSclOe, link.devSdaOe, sleepState}), 16'h1, "released then sleep");
        link.extSclLow = 1'b0;
      end
    join
    chk(16'(rspNack), 16'h1, "cut transfer nacked");
    $display("hold test done");
  endtask

  task test_timeout;
    link.extSclLow = 1'b1;
    step(TO + 40);
    chk(16'(sleepState), 16'h1, "sleep after timeout");
    ce = 1'b0;
    link.extSclLow = 1'b0;
    step(20);
    chk(16'(sleepState), 16'h1, "sleep frozen");
    ce = 1'b1;
    step(20);
    chk(16'(sleepState), 16'h0, "sleep left");
    $display("timeout test done");
  endtask

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    {reqValid, reqRead, reqQuick, flashBusy, deepIdle, lowPower, gaugeWrEn} = '0;
    {reqCmd, reqLen, reqWrData, gaugeWrAddr, gaugeWrData} = '0;
    reqWait = WAIT_CMD_GAP;
    link.extSclLow = 1'b0;
    link.extSdaLow = 1'b0;
    step(6);
    sys_rst = 1'b0;
    step(10);
    test_write;
    test_read;
    test_refuse;
    test_hold;
    test_timeout;
    test_done;
  end
endmodule // test_gauge_i2c_target_port

`default_nettype wire
